// ### pfc_defines.vh
`ifndef PFC_DEFINES_VH
`define PFC_DEFINES_VH

// ==========================================================
// register offsets
`define PFC_OFS_SEL1 8'h10
`define PFC_OFS_SEL2 8'h11
`define PFC_OFS_SEL3 8'h12
`define PFC_OFS_SEL4 8'h13
`define PFC_OFS_PRESET 8'h14

// ==========================================================
// reset values
`define PFC_RST_SEL1 8'h7f
`define PFC_RST_SEL2 8'hce
`define PFC_RST_SEL3 8'h42
`define PFC_RST_SEL4 8'hfc
`define PFC_RST_PRESET 8'h01

// ==========================================================
// writable bits; reserved bits stay read-only zero
`define PFC_WMASK_SEL1 8'hff
`define PFC_WMASK_SEL2 8'hff
`define PFC_WMASK_SEL3 8'hfe
`define PFC_WMASK_SEL4 8'hfc
`define PFC_WMASK_PRESET 8'h1f

// ==========================================================
// field positions, select register 1
`define PFC_S1_PIN7 0
`define PFC_S1_PIN4 1
`define PFC_S1_PIN1 4
`define PFC_S1_DIODE3 5
`define PFC_S1_DIODE1 6
`define PFC_S1_VID 7

// field positions, select register 2
`define PFC_S2_PIN23_LO 0
`define PFC_S2_PIN23_HI 1
`define PFC_S2_PIN22 2
`define PFC_S2_PIN21 3
`define PFC_S2_PIN19 4
`define PFC_S2_PIN15 5
`define PFC_S2_PIN13 6
`define PFC_S2_PIN8 7

// field positions, select register 3
`define PFC_S3_PIN27 1
`define PFC_S3_PIN26_LO 2
`define PFC_S3_PIN26_HI 3
`define PFC_S3_PIN25_LO 4
`define PFC_S3_PIN25_HI 5
`define PFC_S3_PIN24_LO 6
`define PFC_S3_PIN24_HI 7

// field positions, select register 4
`define PFC_S4_PIN32 2
`define PFC_S4_PIN31 3
`define PFC_S4_PIN29_LO 4
`define PFC_S4_PIN29_HI 5
`define PFC_S4_PIN28_LO 6
`define PFC_S4_PIN28_HI 7

// field positions, preset register
`define PFC_PR_HI 4

// ==========================================================
// decoded function codes for pins 25, 26, 28, 29
`define PFC_FN_PRIMARY 2'h0
`define PFC_FN_ALT 2'h1
`define PFC_FN_SIGNAL 2'h2
`define PFC_FN_VID 2'h3

`endif

// ### pfc_cfg_reg.v
`timescale 1ns/1ps

// ==========================================================
// one 8-bit configuration register
module pfc_cfg_reg #(
  parameter [7:0] RST_VAL = 8'h00,
  parameter [7:0] WR_MASK = 8'hff
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // control
  input wire sw_rst,
  input wire wr_en,
  input wire [7:0] wdata,
  // value
  output wire [7:0] q
);

  reg [7:0] q_r;
  reg [7:0] q_nxt;

  always @*
  begin
    q_nxt = q_r;
    if (sw_rst)
      q_nxt = RST_VAL;
    else if (wr_en)
      q_nxt = (q_r & ~WR_MASK) | (wdata & WR_MASK);
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      q_r <= RST_VAL;
    else
      q_r <= q_nxt;
  end

  assign q = q_r;

endmodule // pfc_cfg_reg

// ### pfc_pin_decode.v
`timescale 1ns/1ps
`include "pfc_defines.vh"

// ==========================================================
// combinational pin function decode
module pfc_pin_decode (
  // register values
  input wire [7:0] sel1,
  input wire [7:0] sel2,
  input wire [7:0] sel3,
  input wire [7:0] sel4,
  // decoded selections
  output wire vid_mode,
  output wire [3:0] tach_1_4,
  output wire [1:0] pin26_func,
  output wire [1:0] pin25_func,
  output wire [1:0] pin29_func,
  output wire [1:0] pin28_func,
  output wire fan_drive_out_2_sel,
  output wire fan_drive_out_1_sel,
  output wire pair_err
);

  wire [1:0] f26;
  wire [1:0] f25;
  wire [1:0] f29;
  wire [1:0] f28;

  assign vid_mode = sel1[`PFC_S1_VID];
  // bit 1 is pin 4 .. bit 4 is pin 1; index 0 of tach_1_4 is pin 1
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_tach
      assign tach_1_4[i] = sel1[`PFC_S1_PIN1 - i] & ~vid_mode;
    end
  endgenerate

  assign f26 = sel3[`PFC_S3_PIN26_HI:`PFC_S3_PIN26_LO];
  assign f25 = sel3[`PFC_S3_PIN25_HI:`PFC_S3_PIN25_LO];
  assign f29 = sel4[`PFC_S4_PIN29_HI:`PFC_S4_PIN29_LO];
  assign f28 = sel4[`PFC_S4_PIN28_HI:`PFC_S4_PIN28_LO];

  // both upper codes fold to the signal function
  assign pin26_func = f26[1] ? `PFC_FN_SIGNAL : f26;
  assign pin25_func = f25[1] ? `PFC_FN_SIGNAL : f25;
  assign pin29_func = f29[1] ? `PFC_FN_SIGNAL : f29;
  assign pin28_func = vid_mode ? `PFC_FN_VID :
                      (f28[1] ? `PFC_FN_SIGNAL : f28);

  assign fan_drive_out_2_sel = sel4[`PFC_S4_PIN32] & ~vid_mode;
  assign fan_drive_out_1_sel = sel4[`PFC_S4_PIN31] & ~vid_mode;

  // low-voltage pair must be both or neither
  assign pair_err = ~vid_mode &
                    ((f29 == `PFC_FN_ALT) ^ (f28 == `PFC_FN_ALT));

endmodule // pfc_pin_decode

// ### pfc_pin_config.v
// Contract
// - sel1 bit0 picks pin7 high rail or tach
// - sel1 bits1-4 pick gpio or tach, pins 4-1
// - sel1 bit7 forces voltage-id on seven pins
// - sel1 bit5 enables remote diode 3
// - sel1 bit6 enables remote diode 1
// - sel2 [1:0] picks pin23 sense level
// - sel2 bits 2,3,7 pick sense or tach
// - sel2 bits 4,5 levels apply without diode
// - sel2 bit6 picks pin13 sense or fan_drive_out_4
// - sel3 bit1 picks full-fan or intrusion input
// - sel3 [3:2] picks pin26 function
// - sel3 [5:4] picks pin25 function
// - sel3 [7:6] picks pin24 sense level
// - sel4 [5:4] picks pin29 function
// - sel4 [7:6] picks pin28 function
// - preset bits 0-4 enable five presets
// - reserved bits are read-only
// - power-on loads defaults of registers 1-3
// - power-on loads defaults of register 4, preset
`timescale 1ns/1ps
`include "pfc_defines.vh"

module pfc_pin_config (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // device-wide control
  input wire lock_en,
  input wire sw_rst,
  // register access from the management bus engine
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata_r,
  output reg reg_rd_valid_r,
  // pins 1-4 and 7
  output reg [3:0] fan_speed_in_1_4_sel_r,
  output reg fan_speed_in_5_sel_r,
  output reg voltage_id_inputs_en_r,
  // remote diode pins
  output reg remote_diode_3_select_r,
  output reg remote_diode_1_select_r,
  output reg pin19_low_level_r,
  output reg pin15_low_level_r,
  // sense level selects
  output reg [1:0] pin23_level_r,
  output reg [1:0] pin24_level_r,
  // tach / sense pins
  output reg fan_speed_in_8_sel_r,
  output reg fan_speed_in_7_sel_r,
  output reg fan_speed_in_6_sel_r,
  output reg fan_drive_out_4_sel_r,
  // misc functions
  output reg intrusion_sel_r,
  output reg [1:0] pin26_func_r,
  output reg [1:0] pin25_func_r,
  output reg fan_drive_out_2_sel_r,
  output reg fan_drive_out_1_sel_r,
  output reg [1:0] pin29_func_r,
  output reg [1:0] pin28_func_r,
  output reg low_volt_pair_err_r,
  // preset selection
  output reg [4:0] preset_sel_r
);

  // ==========================================================
  // register bank
  localparam NREG = 5;

  wire [7:0] reg_q [0:NREG-1];
  wire [NREG-1:0] hit;
  wire wr_ok;

  // writes under lock or during soft reset are dropped
  assign wr_ok = reg_wr & ~lock_en & ~sw_rst;

  function [7:0] reg_ofs;
    input integer k;
    begin
      case (k)
        0: reg_ofs = `PFC_OFS_SEL1;
        1: reg_ofs = `PFC_OFS_SEL2;
        2: reg_ofs = `PFC_OFS_SEL3;
        3: reg_ofs = `PFC_OFS_SEL4;
        default: reg_ofs = `PFC_OFS_PRESET;
      endcase
    end
  endfunction

  function [7:0] reg_rst;
    input integer k;
    begin
      case (k)
        0: reg_rst = `PFC_RST_SEL1;
        1: reg_rst = `PFC_RST_SEL2;
        2: reg_rst = `PFC_RST_SEL3;
        3: reg_rst = `PFC_RST_SEL4;
        default: reg_rst = `PFC_RST_PRESET;
      endcase
    end
  endfunction

  function [7:0] reg_mask;
    input integer k;
    begin
      case (k)
        0: reg_mask = `PFC_WMASK_SEL1;
        1: reg_mask = `PFC_WMASK_SEL2;
        2: reg_mask = `PFC_WMASK_SEL3;
        3: reg_mask = `PFC_WMASK_SEL4;
        default: reg_mask = `PFC_WMASK_PRESET;
      endcase
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1)
    begin : g_reg
      assign hit[g] = (reg_addr == reg_ofs(g));
      pfc_cfg_reg #(
        .RST_VAL(reg_rst(g)),
        .WR_MASK(reg_mask(g))
      ) u_reg (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sw_rst(sw_rst),
        .wr_en(wr_ok & hit[g]),
        .wdata(reg_wdata),
        .q(reg_q[g])
      );
    end
  endgenerate

  // ==========================================================
  // read path
  reg [7:0] rd_mux;
  integer j;

  always @*
  begin
    rd_mux = 8'h00;
    for (j = 0; j < NREG; j = j + 1)
    begin
      if (hit[j])
        rd_mux = reg_q[j];
    end
  end

  // unmapped offsets read as zero
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_r <= 8'h00;
      reg_rd_valid_r <= 1'b0;
    end
    else
    begin
      reg_rd_valid_r <= reg_rd;
      if (reg_rd)
        reg_rdata_r <= rd_mux;
    end
  end

  // ==========================================================
  // decode
  wire vid_mode;
  wire [3:0] tach_1_4;
  wire [1:0] f26;
  wire [1:0] f25;
  wire [1:0] f29;
  wire [1:0] f28;
  wire fan_drive_out_2;
  wire fan_drive_out_1;
  wire pair_err;

  pfc_pin_decode u_dec (
    .sel1(reg_q[0]),
    .sel2(reg_q[1]),
    .sel3(reg_q[2]),
    .sel4(reg_q[3]),
    .vid_mode(vid_mode),
    .tach_1_4(tach_1_4),
    .pin26_func(f26),
    .pin25_func(f25),
    .pin29_func(f29),
    .pin28_func(f28),
    .fan_drive_out_2_sel(fan_drive_out_2),
    .fan_drive_out_1_sel(fan_drive_out_1),
    .pair_err(pair_err)
  );

  wire [7:0] s1;
  wire [7:0] s2;
  wire [7:0] s3;

  assign s1 = reg_q[0];
  assign s2 = reg_q[1];
  assign s3 = reg_q[2];

  // ==========================================================
  // registered selections
  // outputs lag the registers by one cycle so every pin mux
  // sees a glitch-free flop
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fan_speed_in_1_4_sel_r <= 4'hf;
      fan_speed_in_5_sel_r <= 1'b1;
      voltage_id_inputs_en_r <= 1'b0;
      remote_diode_3_select_r <= 1'b1;
      remote_diode_1_select_r <= 1'b1;
    end
    else
    begin
      fan_speed_in_5_sel_r <= s1[`PFC_S1_PIN7];
      fan_speed_in_1_4_sel_r <= tach_1_4;
      voltage_id_inputs_en_r <= vid_mode;
      remote_diode_3_select_r <= s1[`PFC_S1_DIODE3];
      remote_diode_1_select_r <= s1[`PFC_S1_DIODE1];
    end
  end

  // sense levels
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin19_low_level_r <= 1'b0;
      pin15_low_level_r <= 1'b0;
      pin23_level_r <= 2'h2;
      pin24_level_r <= 2'h1;
    end
    else
    begin
      pin23_level_r <=
        s2[`PFC_S2_PIN23_HI:`PFC_S2_PIN23_LO];
      // level selects are masked while the diode owns the pin
      pin19_low_level_r <=
        s2[`PFC_S2_PIN19] & ~s1[`PFC_S1_DIODE3];
      pin15_low_level_r <=
        s2[`PFC_S2_PIN15] & ~s1[`PFC_S1_DIODE1];
      pin24_level_r <=
        s3[`PFC_S3_PIN24_HI:`PFC_S3_PIN24_LO];
    end
  end

  // tach and fan drive pins
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fan_speed_in_8_sel_r <= 1'b1;
      fan_speed_in_7_sel_r <= 1'b1;
      fan_speed_in_6_sel_r <= 1'b1;
      fan_drive_out_4_sel_r <= 1'b1;
      fan_drive_out_2_sel_r <= 1'b1;
      fan_drive_out_1_sel_r <= 1'b1;
    end
    else
    begin
      fan_speed_in_8_sel_r <= s2[`PFC_S2_PIN22];
      fan_speed_in_7_sel_r <= s2[`PFC_S2_PIN21];
      fan_speed_in_6_sel_r <= s2[`PFC_S2_PIN8];
      fan_drive_out_4_sel_r <= s2[`PFC_S2_PIN13];
      fan_drive_out_2_sel_r <= fan_drive_out_2;
      fan_drive_out_1_sel_r <= fan_drive_out_1;
    end
  end

  // remaining pin functions and presets
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      intrusion_sel_r <= 1'b1;
      pin26_func_r <= `PFC_FN_PRIMARY;
      pin25_func_r <= `PFC_FN_PRIMARY;
      pin29_func_r <= `PFC_FN_SIGNAL;
      pin28_func_r <= `PFC_FN_SIGNAL;
      low_volt_pair_err_r <= 1'b0;
      preset_sel_r <= 5'h01;
    end
    else
    begin
      intrusion_sel_r <= s3[`PFC_S3_PIN27];
      pin26_func_r <= f26;
      pin25_func_r <= f25;
      pin29_func_r <= f29;
      pin28_func_r <= f28;
      // flag only; a mismatched pair is not corrected in hardware
      low_volt_pair_err_r <= pair_err;
      preset_sel_r <= reg_q[4][`PFC_PR_HI:0];
    end
  end

endmodule // pfc_pin_config

// ### pfc_pin_config_checker.sv
`timescale 1ns/1ps

module pfc_pin_config_checker (
  // clock and reset
  input logic ref_clk,
  input logic rst_n,
  // control and register port
  input logic lock_en,
  input logic sw_rst,
  input logic [7:0] reg_addr,
  input logic reg_wr,
  input logic [7:0] reg_wdata,
  input logic reg_rd,
  input logic [7:0] reg_rdata_r,
  input logic reg_rd_valid_r,
  // decoded selections
  input logic [3:0] fan_speed_in_1_4_sel_r,
  input logic fan_speed_in_5_sel_r,
  input logic voltage_id_inputs_en_r,
  input logic remote_diode_3_select_r,
  input logic remote_diode_1_select_r,
  input logic pin19_low_level_r,
  input logic pin15_low_level_r,
  input logic [1:0] pin26_func_r,
  input logic [1:0] pin25_func_r,
  input logic fan_drive_out_2_sel_r,
  input logic fan_drive_out_1_sel_r,
  input logic [1:0] pin29_func_r,
  input logic [1:0] pin28_func_r,
  input logic low_volt_pair_err_r,
  input logic [4:0] preset_sel_r
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // register port
  unmapped_zero_a: assert property (
    reg_rd && (reg_addr < 8'h10 || reg_addr > 8'h14) |=> reg_rdata_r == 8'h00)
    else $error("unmapped read not zero");
  rd_valid_a: assert property (
    reg_rd |=> reg_rd_valid_r)
    else $error("read valid missing");
  wr_readback_a: assert property (
    reg_wr && !lock_en && !sw_rst && reg_addr == 8'h11 ##1
    reg_rd && !reg_wr && !sw_rst && reg_addr == 8'h11
    |=> reg_rdata_r == $past(reg_wdata, 2))
    else $error("written value not read back");
  soft_reset_a: assert property (
    sw_rst |-> ##2 preset_sel_r == 5'h01 && fan_speed_in_5_sel_r &&
    !voltage_id_inputs_en_r && pin28_func_r == 2'h2 && pin26_func_r == 2'h0)
    else $error("soft reset did not restore defaults");

  // ==========================================================
  // decode relations
  vid_override_a: assert property (
    voltage_id_inputs_en_r |-> fan_speed_in_1_4_sel_r == 4'h0 &&
    !fan_drive_out_2_sel_r && !fan_drive_out_1_sel_r && pin28_func_r == 2'h3)
    else $error("voltage id mode not overriding");
  diode_level_a: assert property (
    !(pin19_low_level_r && remote_diode_3_select_r) &&
    !(pin15_low_level_r && remote_diode_1_select_r))
    else $error("level select active with diode on");
  overheat_code_a: assert property (
    pin26_func_r != 2'h3 && pin25_func_r != 2'h3)
    else $error("overheat codes not merged");
  pin29_code_a: assert property (
    pin29_func_r != 2'h3)
    else $error("pin 29 code out of range");
  pair_flag_a: assert property (
    low_volt_pair_err_r == (!voltage_id_inputs_en_r &&
    ((pin29_func_r == 2'h1) != (pin28_func_r == 2'h1))))
    else $error("low volt pair flag wrong");

  cover property (voltage_id_inputs_en_r);
  cover property (low_volt_pair_err_r);
  cover property (reg_wr && lock_en);
  cover property (sw_rst && reg_wr);
endmodule // pfc_pin_config_checker

bind pfc_pin_config pfc_pin_config_checker chk (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .lock_en(lock_en),
  .sw_rst(sw_rst),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_wdata(reg_wdata),
  .reg_rd(reg_rd),
  .reg_rdata_r(reg_rdata_r),
  .reg_rd_valid_r(reg_rd_valid_r),
  .fan_speed_in_1_4_sel_r(fan_speed_in_1_4_sel_r),
  .fan_speed_in_5_sel_r(fan_speed_in_5_sel_r),
  .voltage_id_inputs_en_r(voltage_id_inputs_en_r),
  .remote_diode_3_select_r(remote_diode_3_select_r),
  .remote_diode_1_select_r(remote_diode_1_select_r),
  .pin19_low_level_r(pin19_low_level_r),
  .pin15_low_level_r(pin15_low_level_r),
  .pin26_func_r(pin26_func_r),
  .pin25_func_r(pin25_func_r),
  .fan_drive_out_2_sel_r(fan_drive_out_2_sel_r),
  .fan_drive_out_1_sel_r(fan_drive_out_1_sel_r),
  .pin29_func_r(pin29_func_r),
  .pin28_func_r(pin28_func_r),
  .low_volt_pair_err_r(low_volt_pair_err_r),
  .preset_sel_r(preset_sel_r)
);

// ### tb_pin_function_config.sv
`timescale 1ns/1ps

module tb_pin_function_config;
  // ==========================================================
  // stimulus and observation
  logic ref_clk = 0;
  logic rst_n = 0;
  logic lock_en = 0;
  logic sw_rst = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  wire [7:0] rdata;
  wire rd_valid;
  wire [34:0] dec;
  logic [7:0] sh [0:4];
  int fails = 0;
  int tests_run = 0;
  localparam logic [4:0][7:0] rst_val =
    {8'h01, 8'hfc, 8'h42, 8'hce, 8'h7f};
  localparam logic [4:0][7:0] wr_mask =
    {8'h1f, 8'hfc, 8'hfe, 8'hff, 8'hff};

  pfc_pin_config dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .lock_en(lock_en), .sw_rst(sw_rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata_r(rdata), .reg_rd_valid_r(rd_valid),
    .fan_speed_in_1_4_sel_r(dec[34:31]), .fan_speed_in_5_sel_r(dec[30]),
    .voltage_id_inputs_en_r(dec[29]), .remote_diode_3_select_r(dec[28]),
    .remote_diode_1_select_r(dec[27]), .pin19_low_level_r(dec[26]),
    .pin15_low_level_r(dec[25]), .pin23_level_r(dec[24:23]),
    .pin24_level_r(dec[22:21]), .fan_speed_in_8_sel_r(dec[20]),
    .fan_speed_in_7_sel_r(dec[19]), .fan_speed_in_6_sel_r(dec[18]),
    .fan_drive_out_4_sel_r(dec[17]), .intrusion_sel_r(dec[16]),
    .pin26_func_r(dec[15:14]), .pin25_func_r(dec[13:12]),
    .fan_drive_out_2_sel_r(dec[11]), .fan_drive_out_1_sel_r(dec[10]),
    .pin29_func_r(dec[9:8]), .pin28_func_r(dec[7:6]),
    .low_volt_pair_err_r(dec[5]), .preset_sel_r(dec[4:0])
  );

  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // expectation
  function automatic [1:0] fn(input logic [1:0] x);
    fn = x[1] ? 2'h2 : x;
  endfunction

  function automatic [34:0] exp_dec();
    logic v;
    v = sh[0][7];
    exp_dec = {{sh[0][1], sh[0][2], sh[0][3], sh[0][4]} & {4{!v}},
      sh[0][0], v, sh[0][5], sh[0][6], sh[1][4] & !sh[0][5],
      sh[1][5] & !sh[0][6], sh[1][1:0], sh[2][7:6], sh[1][2], sh[1][3],
      sh[1][7], sh[1][6], sh[2][1], fn(sh[2][3:2]), fn(sh[2][5:4]),
      sh[3][2] & !v, sh[3][3] & !v, fn(sh[3][5:4]),
      v ? 2'h3 : fn(sh[3][7:6]),
      !v && ((sh[3][5:4] == 2'h1) != (sh[3][7:6] == 2'h1)), sh[4][4:0]};
  endfunction

  // ==========================================================
  // bus tasks
  task automatic check(input string nm, input logic [34:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic idle();
    @(negedge ref_clk);
    reg_wr = 0;
    reg_rd = 0;
  endtask

  // the shadow follows only writes the block must accept
  task automatic wr(input logic [7:0] a, d, input logic lk);
    @(negedge ref_clk);
    reg_rd = 0;
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    lock_en = lk;
    if (!lk && a >= 8'h10 && a <= 8'h14)
      sh[a - 8'h10] = d & wr_mask[a - 8'h10];
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    reg_wr = 0;
    reg_rd = 1;
    reg_addr = a;
    @(posedge ref_clk);
    #1;
    v = rdata;
    check("read valid", rd_valid, 1'b1);
  endtask

  task automatic chk_all();
    logic [7:0] v;
    idle();
    idle();
    check("decode", dec, exp_dec());
    check("valid idle", rd_valid, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      rd(8'h10 + i[7:0], v);
      check("register", v, sh[i]);
    end
    idle();
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // tests
  initial
  begin
    logic [7:0] a;
    logic [7:0] e;
    logic [7:0] v;
    void'($urandom(36));
    for (int i = 0; i < 5; i++) sh[i] = rst_val[i];
    repeat (10) @(negedge ref_clk);
    rst_n = 1;
    chk_all();
    for (int i = 0; i < 5; i++) wr(8'h10 + i[7:0], 8'hff, 0);
    chk_all();
    // every two-bit code, with voltage id mode off and on
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h10, {c[2], c[0], c[1], 5'h15}, 0);
      wr(8'h11, {4'h3, 2'h0, c[1:0]}, 0);
      wr(8'h12, {4{c[1:0]}}, 0);
      wr(8'h13, {c[1:0], ~c[1:0], 4'hc}, 0);
      chk_all();
    end
    for (int i = 0; i < 60; i++)
    begin
      a = 8'h0e + 8'($urandom_range(8));
      wr(a, 8'($urandom), $urandom_range(3) == 0);
      rd(a, v);
      e = (a > 8'h0f && a < 8'h15) ? sh[a - 8'h10] : 8'h00;
      check("readback", v, e);
      if (i % 8 == 7) chk_all();
    end
    // soft reset must win over a write in the same cycle
    @(negedge ref_clk);
    sw_rst = 1;
    reg_wr = 1;
    reg_addr = 8'h10;
    reg_wdata = 8'h00;
    lock_en = 0;
    @(negedge ref_clk);
    sw_rst = 0;
    reg_wr = 0;
    for (int i = 0; i < 5; i++) sh[i] = rst_val[i];
    chk_all();
    wr(8'h12, 8'h00, 0);
    @(negedge ref_clk);
    rst_n = 0;
    reg_wr = 0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1;
    for (int i = 0; i < 5; i++) sh[i] = rst_val[i];
    chk_all();
    final_report();
  end

  // generous bound; the sequence needs about 330 cycles
  initial
  begin
    #(4 * 5000);
    fails++;
    final_report();
  end
endmodule // tb_pin_function_config
